//--- design/serial_write_rx.sv
// write-only three-wire receiver: shifts a frame, commits on select fall
// assumes pins are asynchronous and the link clock is below CLK/4
`default_nettype none

module serial_write_rx #(
  parameter int unsigned ADDR_BITS = 8,
  parameter int unsigned DATA_BITS = 8
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // pins
  input  wire logic                 sclk_in,
  input  wire logic                 sdata_in,
  input  wire logic                 select_in,
  // committed write
  output var  logic                 wr_valid_out,
  output var  logic [ADDR_BITS-1:0] wr_addr_out,
  output var  logic [DATA_BITS-1:0] wr_data_out
);

  localparam int unsigned FRAME = ADDR_BITS + DATA_BITS;
  localparam int unsigned CNT_W = $clog2(FRAME + 2);

  if (ADDR_BITS < 1 || DATA_BITS < 1) begin : g_bad_width
    $error("serial_write_rx needs nonzero field widths");
  end

  logic [2:0]       sync_meta;
  logic [2:0]       sync_out;
  logic [2:0]       sync_last;
  logic [FRAME-1:0] shift;
  logic [CNT_W-1:0] count;

  // two flip-flops per pin, then one more stage for edge detection
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_meta <= 3'h0;
      sync_out  <= 3'h0;
      sync_last <= 3'h0;
    end else begin
      sync_meta <= {select_in, sdata_in, sclk_in};
      sync_out  <= sync_meta;
      sync_last <= sync_out;
    end
  end

  // edge decode on the settled copies
  wire sclk_rise   = sync_out[0] && !sync_last[0];
  wire data_bit    = sync_out[1];
  wire select_on   = sync_out[2];
  wire select_rise = sync_out[2] && !sync_last[2];
  wire select_fall = !sync_out[2] && sync_last[2];
  wire count_full  = (count == CNT_W'(FRAME + 1));
  wire frame_ok    = (count == CNT_W'(FRAME));

  // [RL20] msb-first shift
  // count saturates past the frame so a long frame is rejected too
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift <= '0;
      count <= '0;
    end else if (select_rise) begin
      count <= '0;
    end else if (select_on && sclk_rise) begin
      shift <= {shift[FRAME-2:0], data_bit};
      count <= count_full ? count : count + CNT_W'(1);
    end
  end

  // [RL20] commit on select fall
  // only an exact bit count commits; a short or long frame is dropped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_valid_out <= 1'b0;
      wr_addr_out  <= '0;
      wr_data_out  <= '0;
    end else begin
      wr_valid_out <= select_fall && frame_ok;
      if (select_fall && frame_ok) begin
        wr_addr_out <= shift[FRAME-1:DATA_BITS];
        wr_data_out <= shift[DATA_BITS-1:0];
      end
    end
  end

endmodule : serial_write_rx

`default_nettype wire

//--- design/settle_timer.sv
// one-shot down counter: busy for COUNT cycles after a start pulse
// assumes start comes from logic on the same clock
`default_nettype none

module settle_timer #(
  parameter int unsigned COUNT = 3000
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // control
  input  wire logic start_in,
  // status
  output var  logic busy_out,
  output var  logic done_out
);

  localparam int unsigned CNT_W = $clog2(COUNT + 1);

  if (COUNT < 1) begin : g_bad_count
    $error("settle_timer needs COUNT of at least one");
  end

  logic [CNT_W-1:0] count;

  // a start while busy reloads, so the last change sets the deadline
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (start_in) begin
      count <= CNT_W'(COUNT);
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

  // status decode
  assign busy_out = (count != '0);
  assign done_out = (count == CNT_W'(1)) && !start_in;

endmodule : settle_timer

`default_nettype wire

//--- design/tuner_bias_mode_control.sv
// top of the bias mode control core: registers, power states, outputs
// assumes RST_IN high while the I/O supply is low; pins are asynchronous
`default_nettype none

module tuner_bias_mode_control #(
  parameter int unsigned STARTUP_CYCLES = tuner_bias_pkg::STARTUP_CYCLES
) (
  // clock and supply reset
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  // serial write link pins
  input  wire logic SERIAL_CLK_IN,
  input  wire logic SERIAL_DATA_IN,
  input  wire logic SERIAL_SELECT_IN,
  // per-output analog control
  output var  logic [tuner_bias_pkg::CHANNELS-1:0]
                    [tuner_bias_pkg::LEVEL_USED-1:0] LEVEL_CODE_OUT,
  output var  logic [tuner_bias_pkg::CHANNELS-1:0]
                    [tuner_bias_pkg::MV_W-1:0]       TARGET_MV_OUT,
  output var  logic [tuner_bias_pkg::CHANNELS-1:0]   DRIVE_EN_OUT,
  output var  logic [tuner_bias_pkg::CHANNELS-1:0]   PULL_DOWN_OUT,
  // boost rail control
  output var  logic                                  BOOST_EN_OUT,
  output var  logic [tuner_bias_pkg::BOOST_W-1:0]    BOOST_LEVEL_OUT,
  output var  logic [tuner_bias_pkg::MV_W-1:0]       BOOST_MV_OUT,
  // status
  output var  logic [tuner_bias_pkg::STATE_W-1:0]    POWER_STATE_OUT,
  output var  logic                                  SERIAL_EN_OUT,
  output var  logic                                  STARTUP_BUSY_OUT,
  output var  logic                                  LEVEL_SETTLING_OUT
);
  import tuner_bias_pkg::*;

  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > STARTUP_MAX_CYC) begin : g_bad
    $error("startup length must be one cycle up to the longest allowed");
  end

  logic                rst_meta;
  logic                rst_sync;
  power_state_type     state;
  power_state_type     next_state;
  logic [LEVEL_W-1:0]  level [CHANNELS];
  logic [CHANNELS-1:0] output_enables;
  logic [BOOST_W-1:0]  boost_level;
  logic                wr_valid;
  logic [ADDR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic                startup_busy;
  logic                startup_done;
  logic                settle_busy;

  // [RL19] async assert, sync release
  // the supply drop clears everything at once; release waits two edges
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_sync <= rst_meta;
    end
  end

  // [RL15] serial logic shares the supply reset
  serial_write_rx #(
    .ADDR_BITS (ADDR_W),
    .DATA_BITS (DATA_W)
  ) u_rx (
    .clk_in       (CLK_IN),
    .rst_in       (rst_sync),
    .sclk_in      (SERIAL_CLK_IN),
    .sdata_in     (SERIAL_DATA_IN),
    .select_in    (SERIAL_SELECT_IN),
    .wr_valid_out (wr_valid),
    .wr_addr_out  (wr_addr),
    .wr_data_out  (wr_data)
  );

  // write address decode
  wire wr_enables = wr_valid && (wr_addr == OUTPUT_ENABLES_ADDR);
  wire wr_boost   = wr_valid && (wr_addr == BOOST_LEVEL_ADDR);
  wire wr_power   = wr_valid && (wr_addr == POWER_STATE_ADDR);
  wire [STATE_W-1:0] req_state = wr_data[STATE_W-1:0];

  // power command decode against the current state
  wire in_active  = (state == ST_ACTIVE);
  wire in_low     = (state == ST_LOW_POWER);
  // [RL11] full reset request
  wire req_reset  = wr_power && (req_state == ST_STARTUP)
                    && (in_active || in_low);
  // [RL13] low power only from active
  wire req_low    = wr_power && (req_state == ST_LOW_POWER) && in_active;
  // [RL13] wake only by command
  wire req_wake   = wr_power && (req_state == ST_ACTIVE) && in_low;

  // next power state
  always_comb begin
    next_state = state;
    unique case (state)
      // [RL8] leave shutdown once the supply reset is released
      ST_SHUTDOWN: begin
        next_state = ST_STARTUP;
      end
      // [RL10] startup ends by itself
      ST_STARTUP: begin
        if (startup_done) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (req_reset) begin
          next_state = ST_STARTUP;
        end else if (req_low) begin
          next_state = ST_LOW_POWER;
        end
      end
      ST_LOW_POWER: begin
        if (req_reset) begin
          next_state = ST_STARTUP;
        end else if (req_wake) begin
          next_state = ST_ACTIVE;
        end
      end
    endcase
  end

  // entering startup resets registers and starts the startup timer
  wire enter_startup = (next_state == ST_STARTUP) && (state != ST_STARTUP);

  // [RL8] shutdown from any state while the supply is low
  always_ff @(posedge CLK_IN or posedge rst_sync) begin
    if (rst_sync) begin
      state <= ST_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  // [RL16] startup length, default well inside the limit
  settle_timer #(
    .COUNT (STARTUP_CYCLES)
  ) u_startup_timer (
    .clk_in   (CLK_IN),
    .rst_in   (rst_sync),
    .start_in (enter_startup),
    .busy_out (startup_busy),
    .done_out (startup_done)
  );

  // level register write strobes and change detect, one per output
  logic [CHANNELS-1:0] wr_level;
  logic [CHANNELS-1:0] level_changed;
  for (genvar i = 0; i < CHANNELS; i++) begin : g_level_wr
    assign wr_level[i] = wr_valid
                         && (wr_addr == LEVEL_FIRST_ADDR + ADDR_W'(i));
    assign level_changed[i] = wr_level[i] && (wr_data != level[i]);
  end

  // writes while shutdown cannot occur; reset holds the receiver
  // [RL9] defaults reloaded on startup entry
  // [RL7] registers lost in shutdown through the supply reset
  always_ff @(posedge CLK_IN or posedge rst_sync) begin
    if (rst_sync) begin
      // [RL4] boost default 20 V
      boost_level    <= BOOST_LEVEL_RESET;
      // [RL14] all outputs start disabled
      output_enables <= OUTPUT_ENABLES_RESET;
    end else if (enter_startup) begin
      boost_level    <= BOOST_LEVEL_RESET;
      output_enables <= OUTPUT_ENABLES_RESET;
    end else begin
      // [RL3] four-bit boost setting
      if (wr_boost) begin
        boost_level <= wr_data[BOOST_W-1:0];
      end
      // [RL17] each output switchable
      if (wr_enables) begin
        output_enables <= wr_data[CHANNELS-1:0];
      end
    end
  end

  // [RL1] eight-bit level storage per output
  // [RL12] low power keeps the stored levels
  for (genvar i = 0; i < CHANNELS; i++) begin : g_level_reg
    always_ff @(posedge CLK_IN or posedge rst_sync) begin
      if (rst_sync) begin
        level[i] <= LEVEL_RESET;
      end else if (enter_startup) begin
        level[i] <= LEVEL_RESET;
      end else if (wr_level[i]) begin
        level[i] <= wr_data;
      end
    end
  end

  // [RL18] settle window after a live level change
  // host sequencing should wait for this before the next dependent step
  wire settle_start = in_active && (level_changed != '0);

  settle_timer #(
    .COUNT (SETTLE_CYCLES)
  ) u_settle_timer (
    .clk_in   (CLK_IN),
    .rst_in   (rst_sync),
    .start_in (settle_start),
    .busy_out (settle_busy),
    .done_out ()
  );

  // per-output drive decode
  logic [CHANNELS-1:0] level_zero;
  logic [CHANNELS-1:0] next_drive;
  logic [CHANNELS-1:0] next_pull;
  for (genvar i = 0; i < CHANNELS; i++) begin : g_drive
    assign level_zero[i] = (level[i][LEVEL_USED-1:0] == '0);
    // [RL17] live drive in active only
    assign next_drive[i] = in_active && output_enables[i] && !level_zero[i];
    // [RL6] zero code pulls to ground
    assign next_pull[i]  = in_active && level_zero[i];
  end

  // [RL12] boost only in startup and active, never low power
  // [RL9] boost on during startup
  wire next_boost = (state == ST_STARTUP) || in_active;

  // [RL3] boost rail in millivolts, 9 V plus 1 V per step
  wire [MV_W-1:0] next_boost_mv = BOOST_MIN_MV
                                  + MV_W'(boost_level) * BOOST_STEP_MV;

  // output stage: everything leaves from flip-flops
  // [RL7] shutdown leaves both drive and pull low, which is high-Z
  always_ff @(posedge CLK_IN or posedge rst_sync) begin
    if (rst_sync) begin
      DRIVE_EN_OUT       <= '0;
      PULL_DOWN_OUT      <= '0;
      BOOST_EN_OUT       <= 1'b0;
      BOOST_LEVEL_OUT    <= BOOST_LEVEL_RESET;
      BOOST_MV_OUT       <= '0;
      POWER_STATE_OUT    <= ST_SHUTDOWN;
      SERIAL_EN_OUT      <= 1'b0;
      STARTUP_BUSY_OUT   <= 1'b0;
      LEVEL_SETTLING_OUT <= 1'b0;
    end else begin
      DRIVE_EN_OUT       <= next_drive;
      PULL_DOWN_OUT      <= next_pull;
      BOOST_EN_OUT       <= next_boost;
      BOOST_LEVEL_OUT    <= boost_level;
      BOOST_MV_OUT       <= next_boost_mv;
      POWER_STATE_OUT    <= state;
      SERIAL_EN_OUT      <= (state != ST_SHUTDOWN);
      STARTUP_BUSY_OUT   <= startup_busy;
      LEVEL_SETTLING_OUT <= settle_busy;
    end
  end

  // [RL1] only seven bits reach the converter
  // [RL2] about 188 mV per code step
  for (genvar i = 0; i < CHANNELS; i++) begin : g_level_out
    always_ff @(posedge CLK_IN or posedge rst_sync) begin
      if (rst_sync) begin
        LEVEL_CODE_OUT[i] <= '0;
        TARGET_MV_OUT[i]  <= '0;
      end else begin
        LEVEL_CODE_OUT[i] <= level[i][LEVEL_USED-1:0];
        TARGET_MV_OUT[i]  <= MV_W'(level[i][LEVEL_USED-1:0]) * LEVEL_STEP_MV;
      end
    end
  end

  // [RL5] the boost margin is the host's duty; no clamp here on purpose,
  // so a low rail with high codes saturates the amplifier

endmodule : tuner_bias_mode_control

`default_nettype wire

//--- design/tuner_bias_pkg.sv
// constants, register map and power states of the bias mode control core
// assumes one 50 MHz clock; serial pins are asynchronous to it
//
// Summary of operation
// [RL1] level registers hold eight bits, only the low seven set voltage
// [RL2] each level code step is about 188 mV, 128 steps to 24 V
// [RL3] four-bit boost setting selects rail 9 V to 24 V in 1 V steps
// [RL4] boost setting resets to 1011, a 20 V rail
// [RL5] host keeps boost at least 2 V above highest requested output
// [RL6] level code zero disables the output and pulls it to ground
// [RL7] shutdown turns everything off, outputs high-Z, registers lost
// [RL8] shutdown entered at supply-up and whenever the I/O supply drops
// [RL9] startup resets registers, serial works, boost on, outputs high-Z
// [RL10] startup passes to active on its own, code 01 then 00
// [RL11] full-reset command from active or low power returns to startup
// [RL12] low power keeps serial and registers, outputs high-Z, boost off
// [RL13] low power only from active by command; back to active by command
// [RL14] reset clears the three output enables, all outputs start off
// [RL15] supply reset also resets serial logic, retriggers after supply low
// [RL16] shutdown through startup to active within 250 us, typically 180
// [RL17] in active each output programmable, switchable, changes live
// [RL18] level change must be allowed 60 us to settle
// [RL19] supply level is a reset, asserted async, released synchronously
// [RL20] writes arrive MSB first on rising clock, commit on select falling
`default_nettype none

package tuner_bias_pkg;

  // power states, codes as seen in the power state register
  typedef enum logic [1:0] {
    ST_ACTIVE    = 2'h0,
    ST_STARTUP   = 2'h1,
    ST_LOW_POWER = 2'h2,
    ST_SHUTDOWN  = 2'h3
  } power_state_type;

  localparam int unsigned STATE_W     = 2;
  localparam int unsigned CHANNELS    = 3;
  localparam int unsigned LEVEL_W     = 8;
  localparam int unsigned LEVEL_USED  = 7;
  localparam int unsigned BOOST_W     = 4;
  localparam int unsigned MV_W        = 15;

  // serial frame layout: address byte then data byte
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;

  // register addresses within a frame
  localparam logic [7:0] LEVEL_FIRST_ADDR    = 8'h00;
  localparam logic [7:0] LEVEL_SECOND_ADDR   = 8'h01;
  localparam logic [7:0] LEVEL_THIRD_ADDR    = 8'h02;
  localparam logic [7:0] OUTPUT_ENABLES_ADDR = 8'h03;
  localparam logic [7:0] BOOST_LEVEL_ADDR    = 8'h04;
  localparam logic [7:0] POWER_STATE_ADDR    = 8'h05;

  // reset values
  localparam logic [3:0] BOOST_LEVEL_RESET    = 4'hb;
  localparam logic [2:0] OUTPUT_ENABLES_RESET = 3'h0;
  localparam logic [7:0] LEVEL_RESET          = 8'h00;

  // analog scaling in millivolts
  localparam logic [14:0] LEVEL_STEP_MV = 15'h00bc;  // 188 mV
  localparam logic [14:0] BOOST_MIN_MV  = 15'h2328;  // 9000 mV
  localparam logic [14:0] BOOST_STEP_MV = 15'h03e8;  // 1000 mV

  // timing
  localparam int unsigned CLK_MHZ           = 50;
  localparam int unsigned STARTUP_TYP_US    = 180;
  localparam int unsigned STARTUP_MAX_US    = 250;
  localparam int unsigned STARTUP_CYCLES    = STARTUP_TYP_US * CLK_MHZ;
  localparam int unsigned STARTUP_MAX_CYC   = STARTUP_MAX_US * CLK_MHZ;
  localparam int unsigned SETTLE_US         = 60;
  localparam int unsigned SETTLE_CYCLES     = SETTLE_US * CLK_MHZ;

endpackage : tuner_bias_pkg

`default_nettype wire

//--- verif/tuner_bias_host_model.sv
// host side of the write-only serial link: frames msb first
// assumes the bench calls send_frame; select idles low
`default_nettype none
module tuner_bias_host_model (
  // link pins
  output var logic sclk_out,
  output var logic sdata_out,
  output var logic select_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle pins; clock stands still outside frames
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    select_out = 1'b0;
  end

  // msb first, rising edge, commit on select fall
  task automatic send_frame(input logic [15:0] word, input int nbits);
    select_out = 1'b1;
    #60;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdata_out = word[i];
      #60;
      sclk_out = 1'b1;
      #60;
      sclk_out = 1'b0;
    end
    #60;
    select_out = 1'b0;
    sdata_out = ~sdata_out;  // released line, not the last bit
    #200;  // gap well over three core cycles
  endtask : send_frame
endmodule : tuner_bias_host_model
`default_nettype wire

//--- verif/tuner_bias_mode_control_sva.sv
// port-level assertions for the bias mode control core
// assumes a bind from the bench top; one clock domain
`default_nettype none
module tuner_bias_mode_control_sva
  import tuner_bias_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // serial pins
  input wire logic SERIAL_CLK_IN,
  input wire logic SERIAL_DATA_IN,
  input wire logic SERIAL_SELECT_IN,
  // outputs watched
  input wire logic [tuner_bias_pkg::CHANNELS-1:0]
                   [tuner_bias_pkg::LEVEL_USED-1:0] LEVEL_CODE_OUT,
  input wire logic [tuner_bias_pkg::CHANNELS-1:0]
                   [tuner_bias_pkg::MV_W-1:0]       TARGET_MV_OUT,
  input wire logic [tuner_bias_pkg::CHANNELS-1:0]   DRIVE_EN_OUT,
  input wire logic [tuner_bias_pkg::CHANNELS-1:0]   PULL_DOWN_OUT,
  input wire logic                                  BOOST_EN_OUT,
  input wire logic [tuner_bias_pkg::BOOST_W-1:0]    BOOST_LEVEL_OUT,
  input wire logic [tuner_bias_pkg::MV_W-1:0]       BOOST_MV_OUT,
  input wire logic [tuner_bias_pkg::STATE_W-1:0]    POWER_STATE_OUT,
  input wire logic                                  SERIAL_EN_OUT,
  input wire logic                                  STARTUP_BUSY_OUT,
  input wire logic                                  LEVEL_SETTLING_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  wire logic       active = (POWER_STATE_OUT == ST_ACTIVE);
  wire logic [2:0] zero_code = {LEVEL_CODE_OUT[2] == '0,
                                LEVEL_CODE_OUT[1] == '0,
                                LEVEL_CODE_OUT[0] == '0};
  logic [15:0] in_startup;

  // cycles spent in startup; a counter, as the span is too long to unroll
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      in_startup <= '0;
    end else if (POWER_STATE_OUT == ST_STARTUP) begin
      in_startup <= in_startup + 16'h0001;
    end else begin
      in_startup <= '0;
    end
  end

  property p_pull_down;
    PULL_DOWN_OUT == (zero_code & {3{active}});
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down does not follow zero code");
  property p_drive_off;
    !active || DRIVE_EN_OUT != '0 |-> (DRIVE_EN_OUT & zero_code) == '0
      && (active || DRIVE_EN_OUT == '0);
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("output driven while off or at code zero");
  property p_boost_en;
    BOOST_EN_OUT == (active || POWER_STATE_OUT == ST_STARTUP);
  endproperty
  a_boost_en: assert property (p_boost_en)
    else $error("boost enable wrong for power state");
  property p_serial_en;
    SERIAL_EN_OUT == (POWER_STATE_OUT != ST_SHUTDOWN);
  endproperty
  a_serial_en: assert property (p_serial_en)
    else $error("serial enable wrong for power state");
  property p_startup_len;
    in_startup <= STARTUP_CYCLES + 2;
  endproperty
  a_startup_len: assert property (p_startup_len)
    else $error("startup lasted too long");
  property p_startup_exit;
    POWER_STATE_OUT == ST_STARTUP ##1 POWER_STATE_OUT != ST_STARTUP |-> active;
  endproperty
  a_startup_exit: assert property (p_startup_exit)
    else $error("startup left to a state other than active");
  property p_startup_defaults;
    POWER_STATE_OUT == ST_STARTUP && $past(POWER_STATE_OUT) != ST_STARTUP
      |-> BOOST_LEVEL_OUT == BOOST_LEVEL_RESET && LEVEL_CODE_OUT == '0
      && DRIVE_EN_OUT == '0;
  endproperty
  a_startup_defaults: assert property (p_startup_defaults)
    else $error("defaults not loaded on startup entry");
  property p_target_mv;
    TARGET_MV_OUT[0] == 15'(LEVEL_CODE_OUT[0] * LEVEL_STEP_MV)
      && TARGET_MV_OUT[2] == 15'(LEVEL_CODE_OUT[2] * LEVEL_STEP_MV);
  endproperty
  a_target_mv: assert property (p_target_mv)
    else $error("target voltage not code times step");
  property p_boost_mv;
    SERIAL_EN_OUT |->
      BOOST_MV_OUT == 15'(BOOST_MIN_MV + BOOST_STEP_MV * BOOST_LEVEL_OUT);
  endproperty
  a_boost_mv: assert property (p_boost_mv)
    else $error("boost voltage not base plus steps");
  property p_settle;
    $changed(LEVEL_CODE_OUT) && active && $past(active)
      |-> ##[0:2] LEVEL_SETTLING_OUT;
  endproperty
  a_settle: assert property (p_settle)
    else $error("no settle window after live level change");
  property p_low_power_entry;
    POWER_STATE_OUT == ST_LOW_POWER |-> $past(POWER_STATE_OUT) inside
      {ST_ACTIVE, ST_LOW_POWER};
  endproperty
  a_low_power_entry: assert property (p_low_power_entry)
    else $error("low power entered from a state other than active");

  // main scenarios reached
  c_low_power: cover property (POWER_STATE_OUT == ST_LOW_POWER);
  c_pull_down: cover property (PULL_DOWN_OUT != '0);
  c_settle: cover property ($rose(LEVEL_SETTLING_OUT));
endmodule : tuner_bias_mode_control_sva
`default_nettype wire

//--- verif/tuner_bias_mode_control_test.sv
// self-checking bench for the bias mode control core
// assumes the host model drives the link; short startup parameter
`default_nettype none
module tuner_bias_mode_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tuner_bias_pkg::*;

  localparam int unsigned STARTUP = 20;
  logic clk, rst, sclk, sdata, select, boost_en, serial_en, busy, settling;
  logic [2:0][6:0] level_code;
  logic [2:0][14:0] target_mv;
  logic [2:0] drive_en, pull_down;
  logic [3:0] boost_level;
  logic [14:0] boost_mv;
  logic [1:0] power_state;
  int failures = 0;
  int checks = 0;

  tuner_bias_mode_control #(.STARTUP_CYCLES(STARTUP)) dut_u (
    .CLK_IN(clk), .RST_IN(rst), .SERIAL_CLK_IN(sclk),
    .SERIAL_DATA_IN(sdata), .SERIAL_SELECT_IN(select),
    .LEVEL_CODE_OUT(level_code), .TARGET_MV_OUT(target_mv),
    .DRIVE_EN_OUT(drive_en), .PULL_DOWN_OUT(pull_down),
    .BOOST_EN_OUT(boost_en), .BOOST_LEVEL_OUT(boost_level),
    .BOOST_MV_OUT(boost_mv), .POWER_STATE_OUT(power_state),
    .SERIAL_EN_OUT(serial_en), .STARTUP_BUSY_OUT(busy),
    .LEVEL_SETTLING_OUT(settling));
  tuner_bias_host_model host_u (
    .sclk_out(sclk), .sdata_out(sdata), .select_out(select));

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // inputs change one ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host_u.send_frame({addr, data}, 16);
    cyc(8);  // sync, commit and output lag
  endtask : wr

  task automatic wait_state(input logic [1:0] exp, input int max);
    for (int i = 0; i < max && power_state !== exp; i++) cyc(1);
    chk(power_state, exp);
  endtask : wait_state

  task automatic t_reset;
    int n;
    n = 0;
    cyc(4);
    chk(power_state, ST_SHUTDOWN);
    chk(boost_level, 4'hb);
    chk({drive_en, pull_down, boost_en, serial_en}, 0);
    rst = 1'b0;
    wait_state(ST_STARTUP, 8);
    chk({busy, boost_en, serial_en, drive_en}, 6'b111000);
    while (power_state === ST_STARTUP && n < 300) begin
      n++;
      cyc(1);
    end
    chk(n >= STARTUP - 1 && n <= STARTUP + 1, 1);
    chk({busy, power_state}, {1'b0, ST_ACTIVE});
  endtask : t_reset

  // rail stays 2 V above outputs: levels are zero here
  task automatic t_boost;
    logic [3:0] vals [3] = '{4'h0, 4'hf, 4'hb};
    foreach (vals[i]) begin
      wr(BOOST_LEVEL_ADDR, {4'h0, vals[i]});
      chk(boost_level, vals[i]);
      chk(boost_mv, 9000 + 1000 * vals[i]);
    end
  endtask : t_boost

  task automatic t_levels;
    int n;
    n = 0;
    wr(OUTPUT_ENABLES_ADDR, 8'h07);
    wr(LEVEL_FIRST_ADDR, 8'h8b);
    wr(LEVEL_THIRD_ADDR, 8'h00);
    // changing write last, so the window count starts here
    wr(LEVEL_SECOND_ADDR, 8'h55);
    chk(level_code[0], 7'h0b);
    chk(target_mv[1], 85 * 188);
    chk(drive_en, 3'b011);
    chk(pull_down, 3'b100);
    chk(settling, 1);
    while (settling === 1'b1 && n < 3100) begin
      n++;
      cyc(1);
    end
    chk(n >= 2950 && n < 3000, 1);
    wr(OUTPUT_ENABLES_ADDR, 8'h02);
    chk({drive_en, pull_down}, 6'b010100);
  endtask : t_levels

  task automatic t_low_power;
    wr(POWER_STATE_ADDR, 8'h02);
    wait_state(ST_LOW_POWER, 4);
    chk({boost_en, serial_en, drive_en, pull_down}, 8'h40);
    wr(POWER_STATE_ADDR, 8'h00);
    wait_state(ST_ACTIVE, 4);
    chk(level_code[1], 7'h55);
    chk(drive_en, 3'b010);
  endtask : t_low_power

  // short frame and unmapped address are both ignored
  task automatic t_refused;
    host_u.send_frame({LEVEL_SECOND_ADDR, 8'h11}, 15);
    cyc(8);
    chk(level_code[1], 7'h55);
    wr(8'h06, 8'h01);
    chk({power_state, level_code[1]}, {ST_ACTIVE, 7'h55});
  endtask : t_refused

  task automatic t_full_reset;
    wr(BOOST_LEVEL_ADDR, 8'h0c);
    host_u.send_frame({POWER_STATE_ADDR, 8'h01}, 16);
    wait_state(ST_STARTUP, 10);
    chk({boost_level, level_code, drive_en}, {4'hb, 24'h0});
    wait_state(ST_ACTIVE, STARTUP + 4);
  endtask : t_full_reset

  task automatic t_io_drop;
    wr(LEVEL_FIRST_ADDR, 8'h20);
    rst = 1'b1;
    cyc(2);
    chk({power_state, serial_en}, {ST_SHUTDOWN, 1'b0});
    rst = 1'b0;
    wait_state(ST_STARTUP, 8);
    chk(level_code[0], 0);
    wait_state(ST_ACTIVE, STARTUP + 4);
    wr(LEVEL_FIRST_ADDR, 8'h03);
    chk(level_code[0], 7'h03);
  endtask : t_io_drop

  // main sequence
  initial begin
    rst = 1'b1;
    t_reset();
    t_boost();
    t_levels();
    t_low_power();
    t_refused();
    t_full_reset();
    t_io_drop();
    summarize();
  end

  // watchdog well past the expected run
  initial begin
    #400us;
    failures++;
    summarize();
  end
endmodule : tuner_bias_mode_control_test

bind tuner_bias_mode_control tuner_bias_mode_control_sva #(
  .STARTUP_CYCLES(STARTUP_CYCLES)) sva_u (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .SERIAL_CLK_IN(SERIAL_CLK_IN),
  .SERIAL_DATA_IN(SERIAL_DATA_IN), .SERIAL_SELECT_IN(SERIAL_SELECT_IN),
  .LEVEL_CODE_OUT(LEVEL_CODE_OUT), .TARGET_MV_OUT(TARGET_MV_OUT),
  .DRIVE_EN_OUT(DRIVE_EN_OUT), .PULL_DOWN_OUT(PULL_DOWN_OUT),
  .BOOST_EN_OUT(BOOST_EN_OUT), .BOOST_LEVEL_OUT(BOOST_LEVEL_OUT),
  .BOOST_MV_OUT(BOOST_MV_OUT), .POWER_STATE_OUT(POWER_STATE_OUT),
  .SERIAL_EN_OUT(SERIAL_EN_OUT), .STARTUP_BUSY_OUT(STARTUP_BUSY_OUT),
  .LEVEL_SETTLING_OUT(LEVEL_SETTLING_OUT));
`default_nettype wire
